//--- verilog/module_disable_and_osc_tune.v
// Purpose: Register bank holding peripheral disable bits and the fast RC oscillator trim.
// Assumes: APB slave on core_clk, asynchronous active-low reset nrst.
// Notes: The bank answers with no wait states and every stored bit clears on reset.
// Notes on behaviour
// RULE_01: Bits 15 to 8 of the capture disable register each switch off one input capture unit.
// RULE_02: Bits 7 to 0 of the capture disable register each switch off one output compare unit.
// RULE_03: Bit 4 of the second disable register switches the DMA controller off when one.
// RULE_04: Bit 3 of the second disable register switches the trigger generator off when one.
// RULE_05: All other bits of the second disable register read zero and ignore writes.
// RULE_06: A zero trim code leaves the fast RC oscillator at its nominal centre frequency.
// RULE_07: Positive trim codes raise the frequency by about 0.047 percent per count.
// RULE_08: Trim codes with the top bit set are negative two's-complement steps.
// RULE_09: The one DMA disable bit acts on all four DMA channels together.
// RULE_10: A disabled unit has its clock gated and is held in reset until re-enabled.
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "module_disable_consts.vh"
module module_disable_and_osc_tune (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  output wire [7:0] capture_unit_off_bits,
  output wire [7:0] compare_unit_off_bits,
  output wire [7:0] capture_clk_en,
  output wire [7:0] capture_rst_n,
  output wire [7:0] compare_clk_en,
  output wire [7:0] compare_rst_n,
  output wire [`DMA_CHANNELS-1:0] dma_channel_off,
  output wire dma_clk_en,
  output wire dma_rst_n,
  output wire trigger_generator_off,
  output wire trig_clk_en,
  output wire trig_rst_n,
  output wire [5:0] trim_code,
  output wire signed [6:0] trim_steps
);
  reg [`CCD_W-1:0] ccd_r;
  reg dma_off_r;
  reg trig_off_r;
  reg [`TRIM_W-1:0] trim_r;

  wire [`CCD_W-1:0] ccd_nxt;
  reg dma_off_nxt;
  reg trig_off_nxt;
  reg [`TRIM_W-1:0] trim_nxt;
  reg [31:0] prdata_nxt;

  reg sel_trim;
  reg sel_ccd;
  reg sel_dtg;
  reg map_hit;
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire rd_en;
  wire trim_we;
  wire dtg_we;
  wire [1:0] ccd_lane_we;
  genvar b;
  genvar i;
  genvar c;

  // Registers answer with no wait states; unmapped addresses return an error and read zero.
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign pslverr = access_phase & ~map_hit;
  assign wr_en = access_phase & pwrite & map_hit;
  assign rd_en = setup_phase & ~pwrite;

  // Only the three mapped words answer; any other offset flags an error.
  always @* begin
    sel_trim = 1'b0;
    sel_ccd = 1'b0;
    sel_dtg = 1'b0;
    case (paddr)
      `OFS_FAST_RC_TRIM: begin
        sel_trim = 1'b1;
      end
      `OFS_CAPTURE_COMPARE_DISABLE: begin
        sel_ccd = 1'b1;
      end
      `OFS_DMA_TRIGGER_GEN_DISABLE: begin
        sel_dtg = 1'b1;
      end
      default: begin
        sel_trim = 1'b0;
        sel_ccd = 1'b0;
        sel_dtg = 1'b0;
      end
    endcase
    map_hit = sel_trim | sel_ccd | sel_dtg;
  end

  // A write lands at the access edge only; lanes above the low two carry no stored bits.
  assign trim_we = wr_en & sel_trim & pstrb[`LANE_LOW];
  assign dtg_we = wr_en & sel_dtg & pstrb[`LANE_LOW];
  assign ccd_lane_we[0] = wr_en & sel_ccd & pstrb[`LANE_LOW]; // RULE_02
  assign ccd_lane_we[1] = wr_en & sel_ccd & pstrb[`LANE_HIGH]; // RULE_01

  // Each byte lane guards its own eight disable bits.
  generate
    for (b = 0; b < `CCD_W; b = b + 1) begin : g_ccd_bit
      assign ccd_nxt[b] = ccd_lane_we[b / `LANE_W] ? pwdata[b] : ccd_r[b]; // RULE_01 RULE_02
    end
  endgenerate

  always @* begin
    dma_off_nxt = dma_off_r;
    if (dtg_we) begin
      dma_off_nxt = pwdata[`DMA_OFF_BIT]; // RULE_03
    end
  end

  always @* begin
    trig_off_nxt = trig_off_r;
    if (dtg_we) begin
      trig_off_nxt = pwdata[`TRIG_OFF_BIT]; // RULE_04
    end
  end

  always @* begin
    trim_nxt = trim_r;
    if (trim_we) begin
      trim_nxt = pwdata[`TRIM_W-1:0]; // RULE_06
    end
  end

  // Read data is registered in the setup cycle so it is stable through the access phase.
  always @* begin
    prdata_nxt = prdata;
    if (rd_en) begin
      case (paddr)
        `OFS_FAST_RC_TRIM: begin
          prdata_nxt = {{(32 - `TRIM_W){1'h0}}, trim_r};
        end
        `OFS_CAPTURE_COMPARE_DISABLE: begin
          prdata_nxt = {{(32 - `CCD_W){1'h0}}, ccd_r};
        end
        `OFS_DMA_TRIGGER_GEN_DISABLE: begin
          prdata_nxt = `READ_ZERO; // RULE_05
          prdata_nxt[`DMA_OFF_BIT] = dma_off_r;
          prdata_nxt[`TRIG_OFF_BIT] = trig_off_r;
        end
        default: begin
          prdata_nxt = `READ_ZERO;
        end
      endcase
    end
  end

  // Every stored bit clears on reset so all units start enabled.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ccd_r <= `CCD_RESET;
    end else begin
      ccd_r <= ccd_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dma_off_r <= `DTG_RESET;
      trig_off_r <= `DTG_RESET;
    end else begin
      dma_off_r <= dma_off_nxt;
      trig_off_r <= trig_off_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trim_r <= `TRIM_RESET;
    end else begin
      trim_r <= trim_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= `PRDATA_RESET;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // The unit controls are plain inverters of flip-flops, so they cannot glitch.
  generate
    for (i = 0; i < `UNIT_COUNT; i = i + 1) begin : g_unit
      wire cap_off;
      wire cmp_off;
      assign cap_off = ccd_r[`CAPTURE_LSB + i];
      assign cmp_off = ccd_r[`COMPARE_LSB + i];
      assign capture_unit_off_bits[i] = cap_off; // RULE_01
      assign compare_unit_off_bits[i] = cmp_off; // RULE_02
      assign capture_clk_en[i] = ~cap_off; // RULE_10
      assign capture_rst_n[i] = ~cap_off; // RULE_10
      assign compare_clk_en[i] = ~cmp_off; // RULE_10
      assign compare_rst_n[i] = ~cmp_off; // RULE_10
    end
  endgenerate

  generate
    for (c = 0; c < `DMA_CHANNELS; c = c + 1) begin : g_dma_ch
      assign dma_channel_off[c] = dma_off_r; // RULE_09
    end
  endgenerate
  assign dma_clk_en = ~dma_off_r; // RULE_10
  assign dma_rst_n = ~dma_off_r; // RULE_10

  assign trigger_generator_off = trig_off_r; // RULE_04
  assign trig_clk_en = ~trig_off_r; // RULE_10
  assign trig_rst_n = ~trig_off_r; // RULE_10

  // The analog cell takes the raw code; the signed step count is for the trim DAC decoder.
  assign trim_code = trim_r; // RULE_06
  assign trim_steps = {trim_r[`TRIM_W-1], trim_r}; // RULE_07 RULE_08
endmodule // module_disable_and_osc_tune

//--- verilog/module_disable_consts.vh
// Purpose: Offsets, field positions and reset values of the module disable and trim bank.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Offsets are local to the bank.
`ifndef MODULE_DISABLE_CONSTS_VH
`define MODULE_DISABLE_CONSTS_VH
`define OFS_FAST_RC_TRIM 12'h000
`define OFS_CAPTURE_COMPARE_DISABLE 12'h004
`define OFS_DMA_TRIGGER_GEN_DISABLE 12'h008
`define TRIM_W 6
`define TRIM_RESET 6'h00
`define CCD_RESET 16'h0000
`define CAPTURE_LSB 8
`define COMPARE_LSB 0
`define DMA_OFF_BIT 4
`define TRIG_OFF_BIT 3
`define DTG_RESET 1'b0
`define DMA_CHANNELS 4
`define CCD_W 16
`define UNIT_COUNT 8
`define LANE_W 8
`define LANE_LOW 0
`define LANE_HIGH 1
`define READ_ZERO 32'h0000_0000
`define PRDATA_RESET 32'h0000_0000
`endif

//--- dv/md_chk_asserts.sv
// Purpose: Port level checks of the disable and trim bank.
// Assumes: The slave answers every access phase at once.
// Notes: Write checks only look at transfers with both low byte lanes enabled.
module md_chk (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [3:0] pstrb,
  input wire [3:0] dma_channel_off,
  input wire [7:0] capture_unit_off_bits,
  input wire [7:0] compare_unit_off_bits,
  input wire [7:0] capture_clk_en,
  input wire [7:0] capture_rst_n,
  input wire [7:0] compare_clk_en,
  input wire [7:0] compare_rst_n,
  input wire dma_clk_en,
  input wire dma_rst_n,
  input wire trigger_generator_off,
  input wire trig_clk_en,
  input wire trig_rst_n,
  input wire [5:0] trim_code,
  input wire signed [6:0] trim_steps
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire wr = psel && penable && pwrite && pstrb[1:0] == 2'b11;
  property p_ic; capture_clk_en == ~capture_unit_off_bits; endproperty
  a_ic: assert property (p_ic) else $error("cap gate");
  property p_oc; compare_rst_n == ~compare_unit_off_bits; endproperty
  a_oc: assert property (p_oc) else $error("cmp reset");
  property p_dm; dma_channel_off == {4{!dma_clk_en}}; endproperty
  a_dm: assert property (p_dm) else $error("dma");
  property p_tg; trig_rst_n == !trigger_generator_off; endproperty
  a_tg: assert property (p_tg) else $error("trg");
  property p_st; trim_steps == {trim_code[5], trim_code}; endproperty
  a_st: assert property (p_st) else $error("steps");
  property p_wc; wr && paddr == 12'h004 |=> {capture_unit_off_bits,
    compare_unit_off_bits} == $past(pwdata[15:0]); endproperty
  a_wc: assert property (p_wc) else $error("ccd write");
  property p_wd; wr && paddr == 12'h008 |=> {dma_channel_off[0], trigger_generator_off}
    == $past(pwdata[4:3]); endproperty
  a_wd: assert property (p_wd) else $error("dtg write");
  property p_rd; psel && penable && !pwrite && paddr == 12'h008 |-> prdata[2:0] == 3'h0
    && prdata[31:5] == 27'h0; endproperty
  a_rd: assert property (p_rd) else $error("dtg read");
  property p_tw; wr && paddr == 12'h000 |=> trim_code == $past(pwdata[5:0]); endproperty
  a_tw: assert property (p_tw) else $error("trim write");
  property p_ir; capture_rst_n == ~capture_unit_off_bits; endproperty
  a_ir: assert property (p_ir) else $error("cap reset");
  property p_oe; compare_clk_en == ~compare_unit_off_bits; endproperty
  a_oe: assert property (p_oe) else $error("cmp gate");
  property p_dr; dma_rst_n == !dma_channel_off[3]; endproperty
  a_dr: assert property (p_dr) else $error("dma reset");
  property p_te; trig_clk_en == !trigger_generator_off; endproperty
  a_te: assert property (p_te) else $error("trg gate");
  c_w: cover property (wr && paddr == 12'h004);
  c_n: cover property (trim_code == 6'h20);
  c_d: cover property (dma_channel_off == 4'hf);
endmodule // md_chk
bind module_disable_and_osc_tune md_chk u_chk (
  .core_clk(core_clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pstrb(pstrb),
  .dma_channel_off(dma_channel_off),
  .capture_unit_off_bits(capture_unit_off_bits),
  .compare_unit_off_bits(compare_unit_off_bits),
  .capture_clk_en(capture_clk_en),
  .capture_rst_n(capture_rst_n),
  .compare_clk_en(compare_clk_en),
  .compare_rst_n(compare_rst_n),
  .dma_clk_en(dma_clk_en),
  .dma_rst_n(dma_rst_n),
  .trigger_generator_off(trigger_generator_off),
  .trig_clk_en(trig_clk_en),
  .trig_rst_n(trig_rst_n),
  .trim_code(trim_code),
  .trim_steps(trim_steps)
);

//--- dv/module_disable_and_osc_tune_tb_top.sv
// Purpose: Random and directed test of the disable and trim bank over APB.
// Assumes: The master waits for pready, however soon the slave answers.
// Notes: Write strobes are drawn at random after the first few transfers.
module module_disable_and_osc_tune_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, d, m[4], k[4] = '{32'h3f, 32'hffff, 32'h18, 32'h0};
  logic [3:0] pstrb = 4'hf, s;
  int bad_count, checks, i, a, seed = 32'h4177823a;
  wire pready, pslverr, dma_clk_en, dma_rst_n, trigger_generator_off, trig_clk_en, trig_rst_n;
  wire [31:0] prdata;
  wire [7:0] capture_unit_off_bits, compare_unit_off_bits, capture_clk_en, capture_rst_n;
  wire [7:0] compare_clk_en, compare_rst_n;
  wire [3:0] dma_channel_off;
  wire [5:0] trim_code;
  wire signed [6:0] trim_steps;
  module_disable_and_osc_tune DUT (.*);
  always #12.5 core_clk = ~core_clk;
  task ck(input string n, input [31:0] e, v);
    checks++;
    if (e !== v) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, v);
    end
  endtask
  function automatic logic [6:0] exp_steps(input logic [5:0] c);
    int n;
    n = c;
    if (c[5]) n = n - 64;
    return 7'(n);
  endfunction
  task apb(input w, input [11:0] ad, input [31:0] wd, input [3:0] st);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, ad, wd, st};
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000 bad_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1;
    for (i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), 0, 4'hf);
      ck("reset", 0, rd);
    end
    for (i = 0; i < 6; i++) begin
      d = (i == 5) ? 1 : (i == 4) ? 32 : i * 21;
      apb(1, 12'h000, d, 4'hf);
      @(negedge core_clk);
      ck("trim", d[5:0], trim_code);
      ck("steps", exp_steps(d[5:0]), {25'h0, trim_steps});
    end
    m = '{32'h1, 0, 0, 0};
    for (i = 0; i < 40; i++) begin
      a = $random(seed) & 3;
      d = $random(seed);
      s = (i < 8) ? 4'hf : 4'($random(seed));
      apb(1, 12'(a * 4), d, s);
      if (s[0]) m[a][7:0] = d[7:0] & k[a][7:0];
      if (s[1]) m[a][15:8] = d[15:8] & k[a][15:8];
      ck("error", a == 3, er);
      apb(0, 12'(a * 4), 0, 4'hf);
      ck("read", m[a], rd);
      ck("ccd", m[1], {capture_unit_off_bits, compare_unit_off_bits});
      ck("dma", {4{m[2][4]}}, dma_channel_off);
      ck("trg", m[2][3], trigger_generator_off);
    end
    @(posedge core_clk);
    nrst <= 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1;
    ck("rst ccd", 0, {capture_unit_off_bits, compare_unit_off_bits});
    ck("rst gates", 32'hffff_ffff, {capture_clk_en, capture_rst_n, compare_clk_en, compare_rst_n});
    ck("rst dtg", 0, {dma_channel_off, trigger_generator_off, trim_code});
    for (i = 0; i < 3; i++) begin
      apb(0, 12'(i * 4), 0, 4'hf);
      ck("reread", 0, rd);
    end
    end_sim;
  end
endmodule // module_disable_and_osc_tune_tb_top
